// ===== rtl/pmt_pkg.sv
package pmt_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int NUM_CHAN = 2;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OT_FAULT_LIM = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN_LIM = 8'h51;
  localparam logic [7:0] CMD_UT_FAULT_LIM = 8'h53;
  localparam logic [7:0] CMD_TOFF_LIM = 8'h66;
  localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7A;
  localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7B;
  localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7C;
  localparam logic [7:0] CMD_TEMP_FLAGS = 8'h7D;
  localparam logic [7:0] CMD_CML_FLAGS = 8'h7E;
  localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;
  localparam logic [7:0] CMD_VENDOR_INFO = 8'hB6;
  localparam logic [7:0] CMD_PAD_STATE = 8'hE5;
  localparam logic [7:0] CMD_GENERIC_FLAGS = 8'hEF;
  localparam logic [7:0] CMD_TEMP_SLOPE = 8'hF8;
  localparam logic [7:0] CMD_TEMP_ADDEND = 8'hF9;

  // reset values
  localparam logic [15:0] RST_OT_FAULT_LIM = 16'hEB20;
  localparam logic [15:0] RST_OT_WARN_LIM = 16'hEAA8;
  localparam logic [15:0] RST_UT_FAULT_LIM = 16'hE580;
  localparam logic [15:0] RST_TOFF_LIM = 16'hF258;
  localparam logic [15:0] RST_TEMP_SLOPE = 16'h4000;
  localparam logic [15:0] RST_TEMP_ADDEND = 16'h8000;

  // implemented bits of each flag byte
  localparam logic [7:0] VOUT_MASK = 8'hFE;
  localparam logic [7:0] IOUT_MASK = 8'hA0;
  localparam logic [7:0] INPUT_MASK = 8'hA8;
  localparam logic [7:0] INPUT_W1C_MASK = 8'h80;
  localparam logic [7:0] TEMP_MASK = 8'hD0;
  localparam logic [7:0] CML_MASK = 8'hFB;
  localparam logic [7:0] VENDOR_MASK = 8'hFB;

  // field positions
  localparam int TEMP_OT_FAULT_BIT = 7;
  localparam int TEMP_OT_WARN_BIT = 6;
  localparam int TEMP_UT_FAULT_BIT = 4;
  localparam int VOUT_TOFF_WARN_BIT = 1;
  localparam int CML_BAD_CMD_BIT = 7;
  localparam int CML_BAD_DATA_BIT = 6;
  localparam int SUM_BUSY_BIT = 7;
  localparam int CFG_NO_TOFF_BIT = 0;
  localparam int MODE_ADDEND_VOLTS_BIT = 5;
  localparam int L11_FRAC_BITS = 16;

  // exponent-5 mantissa-11 value to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11_to_fix(input logic [15:0] v);
    logic signed [47:0] mant;
    logic [4:0] shift;
    mant = 48'(signed'(v[10:0]));
    shift = v[15:11] + 5'(L11_FRAC_BITS);
    return mant <<< shift;
  endfunction

  // sticky flag update: an event in the clearing cycle still lands
  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                        input logic [7:0] clr, input logic [7:0] mask);
    return ((cur & ~clr) | set) & mask;
  endfunction

endpackage

// ===== rtl/pmt_temp_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module pmt_temp_cmp
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // calibrated reading of one channel
  input wire logic i_valid,
  input wire logic [15:0] i_temp,
  // thresholds
  input wire logic [15:0] i_ot_fault_lim,
  input wire logic [15:0] i_ot_warn_lim,
  input wire logic [15:0] i_ut_fault_lim,
  // one-cycle crossing events
  output logic o_ot_fault,
  output logic o_ot_warn,
  output logic o_ut_fault
);

  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic ut_fault;
  } pmt_cmp_s;

  pmt_cmp_s st;
  pmt_cmp_s next_st;

  // compare only on a fresh reading, so each sample gives one event
  always_comb begin
    next_st = '0;
    if (i_valid) begin
      next_st.ot_fault = l11_to_fix(i_temp) > l11_to_fix(i_ot_fault_lim);
      next_st.ot_warn = l11_to_fix(i_temp) > l11_to_fix(i_ot_warn_lim);
      next_st.ut_fault = l11_to_fix(i_temp) <= l11_to_fix(i_ut_fault_lim);
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ot_fault = st.ot_fault;
  assign o_ot_warn = st.ot_warn;
  assign o_ut_fault = st.ut_fault;

endmodule
`default_nettype wire

// ===== rtl/pmt_toff_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pmt_toff_timer
  import pmt_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // sequencing
  input wire logic i_fall_done,
  input wire logic i_out_low,
  input wire logic [15:0] i_limit,
  input wire logic i_disable,
  // one-cycle warning
  output logic o_warn
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef enum logic {PMT_IDLE, PMT_WATCH} pmt_tmr_e;

  typedef struct packed {
    pmt_tmr_e state;
    logic [TW-1:0] tick;
    logic [15:0] elapsed_ms;
    logic warn;
  } pmt_tmr_s;

  pmt_tmr_s st;
  pmt_tmr_s next_st;
  logic signed [47:0] elapsed_fix;
  logic signed [47:0] limit_fix;

  // elapsed time in the same fixed point as the limit
  assign elapsed_fix = {16'h0000, st.elapsed_ms, 16'h0000};
  assign limit_fix = l11_to_fix(i_limit);

  // watch the decay after the ramp-down ends
  always_comb begin
    next_st = st;
    next_st.warn = 1'b0;
    unique case (st.state)
      PMT_IDLE: begin
        if (i_fall_done) begin
          next_st.state = PMT_WATCH;
          next_st.tick = '0;
          next_st.elapsed_ms = '0;
        end
      end
      PMT_WATCH: begin
        if (i_out_low) begin
          // output is below 12.5 percent: done without warning
          next_st.state = PMT_IDLE;
        end else if (limit_fix != 0 && !i_disable && elapsed_fix > limit_fix) begin
          next_st.warn = 1'b1;
          next_st.state = PMT_IDLE;
        end else if (st.tick == TW'(TICK_CYCLES - 1)) begin
          next_st.tick = '0;
          // saturate so a disabled check can wait forever
          if (st.elapsed_ms != 16'hFFFF) begin
            next_st.elapsed_ms = st.elapsed_ms + 16'h0001;
          end
        end else begin
          next_st.tick = st.tick + TW'(1);
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_warn = st.warn;

endmodule
`default_nettype wire

// ===== rtl/pmt_status_regs.sv
// Notes on behaviour
// - warn if decay below 12.5% exceeds limit
// - zero timeout limit disables the check
// - channel config bit 0 disables timeout
// - limits and thresholds are two-byte L11
// - addend unit volts when mode bit5
// - per-channel slope word, default 0x4000
// - overtemperature fault above fault threshold
// - overtemp warning sets summary, flag, alert
// - undertemperature fault at or below threshold
// - answer status codes 0x78-0x7E, 0x80
// - input and cml bytes shared, rest paged
// - clear-faults send byte clears all flags
// - read-only pad, generic, vendor info words
// - writing one clears that status bit; input byte only bit 7
// - temp byte bits 7, 6, 4 only
// - summary bit 2 on any temperature flag
`timescale 1ns/10ps
`default_nettype none
module pmt_status_regs
  import pmt_pkg::*;
#(
  parameter int TOFF_TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // command port from the serial front end
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_data,
  input wire logic i_page,
  // read answer
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_rerr,
  // temperature readings per channel
  input wire logic [1:0] i_temp_valid,
  input wire logic [1:0][15:0] i_temp_reading,
  // output sequencing per channel
  input wire logic [1:0] i_fall_done,
  input wire logic [1:0] i_out_low,
  input wire logic [1:0][7:0] i_channel_configuration_word,
  input wire logic [1:0][7:0] i_modulation_mode_word,
  // fault events from other monitors
  input wire logic [1:0][7:0] i_vout_evt,
  input wire logic [1:0][7:0] i_iout_evt,
  input wire logic [1:0][7:0] i_vendor_evt,
  input wire logic [1:0] i_busy_evt,
  input wire logic [7:0] i_input_evt,
  input wire logic [7:0] i_cml_evt,
  // channel levels
  input wire logic [1:0] i_chan_off,
  input wire logic [1:0] i_pgood_n,
  // read-only views
  input wire logic [15:0] i_pad_state,
  input wire logic [7:0] i_generic_flags,
  input wire logic [15:0] i_vendor_info,
  // alert masking of temperature bits, 1 masks
  input wire logic [7:0] i_temp_alert_mask,
  // coefficients and results to the rest of the device
  output logic [1:0][15:0] o_ext_temp_slope,
  output logic [1:0][15:0] o_ext_temp_addend,
  output logic [1:0] o_addend_in_volts,
  output logic [1:0] o_ot_fault,
  output logic [1:0] o_ut_fault,
  output logic o_alert
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (TOFF_TICK_CYCLES < 1) begin : g_bad_tick
    $error("TOFF_TICK_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0][15:0] ot_fault_lim;
    logic [1:0][15:0] ot_warn_lim;
    logic [1:0][15:0] ut_fault_lim;
    logic [1:0][15:0] toff_lim;
    logic [1:0][15:0] slope;
    logic [1:0][15:0] addend;
    logic [1:0] addend_volts;
    logic [1:0][7:0] vout_flags;
    logic [1:0][7:0] iout_flags;
    logic [1:0][7:0] temp_flags;
    logic [1:0][7:0] vendor_flags;
    logic [1:0] busy;
    logic [7:0] input_flags;
    logic [7:0] cml_flags;
    logic [1:0] out_low_s1;
    logic [1:0] out_low_s2;
    logic [15:0] rdata;
    logic rvalid;
    logic rerr;
    logic alert;
  } pmt_regs_s;

  pmt_regs_s st;
  pmt_regs_s next_st;

  // crossing events from the per-channel helpers
  logic [1:0] ot_fault_evt;
  logic [1:0] ot_warn_evt;
  logic [1:0] ut_fault_evt;
  logic [1:0] toff_warn_evt;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // codes that a read may address
  function automatic logic readable(input logic [7:0] code);
    unique case (code)
      CMD_OT_FAULT_LIM, CMD_OT_WARN_LIM, CMD_UT_FAULT_LIM, CMD_TOFF_LIM,
      CMD_SUM_BYTE, CMD_SUM_WORD, CMD_VOUT_FLAGS, CMD_IOUT_FLAGS,
      CMD_INPUT_FLAGS, CMD_TEMP_FLAGS, CMD_CML_FLAGS, CMD_VENDOR_FLAGS,
      CMD_VENDOR_INFO, CMD_PAD_STATE, CMD_GENERIC_FLAGS, CMD_TEMP_SLOPE,
      CMD_TEMP_ADDEND: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // codes that a write may address; read-only views are excluded
  function automatic logic writable(input logic [7:0] code);
    unique case (code)
      CMD_VENDOR_INFO, CMD_PAD_STATE, CMD_GENERIC_FLAGS: return 1'b0;
      CMD_CLEAR_FAULTS: return 1'b1;
      default: return readable(code);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-channel helpers

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    // each channel compares its own latest reading
    pmt_temp_cmp u_cmp (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_valid(i_temp_valid[ch]),
      .i_temp(i_temp_reading[ch]),
      .i_ot_fault_lim(st.ot_fault_lim[ch]),
      .i_ot_warn_lim(st.ot_warn_lim[ch]),
      .i_ut_fault_lim(st.ut_fault_lim[ch]),
      .o_ot_fault(ot_fault_evt[ch]),
      .o_ot_warn(ot_warn_evt[ch]),
      .o_ut_fault(ut_fault_evt[ch])
    );

    // timer sees the comparator only after the two-stage synchroniser
    pmt_toff_timer #(
      .TICK_CYCLES(TOFF_TICK_CYCLES)
    ) u_toff (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_fall_done(i_fall_done[ch]),
      .i_out_low(st.out_low_s2[ch]),
      .i_limit(st.toff_lim[ch]),
      .i_disable(i_channel_configuration_word[ch][CFG_NO_TOFF_BIT]),
      .o_warn(toff_warn_evt[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic wr;
    logic rd;
    logic clr_all;
    logic sel;
    logic [7:0] clr_v;
    logic [7:0] clr_i;
    logic [7:0] clr_t;
    logic [7:0] clr_m;
    logic [7:0] set_t;
    logic [7:0] set_cml;
    logic [7:0] wb;
    logic [7:0] sum;
    logic [7:0] hi;
    logic any_alert;
    wr = i_cmd_valid && i_cmd_write;
    rd = i_cmd_valid && !i_cmd_write;
    clr_all = wr && i_cmd_code == CMD_CLEAR_FAULTS;
    sel = 1'b0;
    clr_v = '0;
    clr_i = '0;
    clr_t = '0;
    clr_m = '0;
    set_t = '0;
    set_cml = '0;
    wb = i_cmd_data[7:0];
    sum = '0;
    hi = '0;
    any_alert = 1'b0;
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.rerr = 1'b0;

    // two-flop synchroniser on the analog decay comparator
    next_st.out_low_s1 = i_out_low;
    next_st.out_low_s2 = st.out_low_s1;

    // an unknown or misdirected command is logged in the shared byte
    if (i_cmd_valid && !(i_cmd_write ? writable(i_cmd_code) : readable(i_cmd_code))) begin
      set_cml[CML_BAD_CMD_BIT] = 1'b1;
    end

    // paged registers and flags
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      sel = wr && (1'(ch) == i_page);
      clr_v = clr_all ? 8'hFF : '0;
      clr_i = clr_all ? 8'hFF : '0;
      clr_t = clr_all ? 8'hFF : '0;
      clr_m = clr_all ? 8'hFF : '0;
      if (sel) begin
        unique case (i_cmd_code)
          CMD_OT_FAULT_LIM: next_st.ot_fault_lim[ch] = i_cmd_data;
          CMD_OT_WARN_LIM: next_st.ot_warn_lim[ch] = i_cmd_data;
          CMD_UT_FAULT_LIM: next_st.ut_fault_lim[ch] = i_cmd_data;
          CMD_TOFF_LIM: next_st.toff_lim[ch] = i_cmd_data;
          CMD_TEMP_SLOPE: next_st.slope[ch] = i_cmd_data;
          CMD_TEMP_ADDEND: next_st.addend[ch] = i_cmd_data;
          CMD_VOUT_FLAGS: clr_v = wb;
          CMD_IOUT_FLAGS: clr_i = wb;
          CMD_TEMP_FLAGS: clr_t = wb;
          CMD_VENDOR_FLAGS: clr_m = wb;
          default: begin
          end
        endcase
      end

      // temperature events: bits 7, 6 and 4 only
      set_t = '0;
      set_t[TEMP_OT_FAULT_BIT] = ot_fault_evt[ch];
      set_t[TEMP_OT_WARN_BIT] = ot_warn_evt[ch];
      set_t[TEMP_UT_FAULT_BIT] = ut_fault_evt[ch];
      next_st.temp_flags[ch] = sticky(st.temp_flags[ch], set_t, clr_t, TEMP_MASK);

      // decay timeout joins the output-voltage flags
      next_st.vout_flags[ch] = sticky(st.vout_flags[ch],
                                      i_vout_evt[ch] | (8'(toff_warn_evt[ch]) << VOUT_TOFF_WARN_BIT),
                                      clr_v, VOUT_MASK);
      next_st.iout_flags[ch] = sticky(st.iout_flags[ch], i_iout_evt[ch], clr_i, IOUT_MASK);
      next_st.vendor_flags[ch] = sticky(st.vendor_flags[ch], i_vendor_evt[ch], clr_m, VENDOR_MASK);

      // busy is the only stored bit of the summary; writing one clears it
      if (i_busy_evt[ch]) begin
        next_st.busy[ch] = 1'b1;
      end else if (clr_all || (sel && (i_cmd_code == CMD_SUM_BYTE || i_cmd_code == CMD_SUM_WORD) &&
                   wb[SUM_BUSY_BIT])) begin
        next_st.busy[ch] = 1'b0;
      end

      // offset unit follows the modulation mode word
      next_st.addend_volts[ch] = i_modulation_mode_word[ch][MODE_ADDEND_VOLTS_BIT];
    end

    // shared flag bytes
    clr_i = clr_all ? 8'hFF : '0;
    clr_m = clr_all ? 8'hFF : '0;
    if (wr && i_cmd_code == CMD_INPUT_FLAGS) begin
      clr_i = wb & INPUT_W1C_MASK;
    end
    if (wr && i_cmd_code == CMD_CML_FLAGS) begin
      clr_m = wb;
    end
    next_st.input_flags = sticky(st.input_flags, i_input_evt, clr_i, INPUT_MASK);
    next_st.cml_flags = sticky(st.cml_flags, i_cml_evt | set_cml, clr_m, CML_MASK);

    // summary of the selected page
    sum[7] = st.busy[i_page];
    sum[6] = i_chan_off[i_page];
    sum[5] = st.vout_flags[i_page][7];
    sum[4] = st.iout_flags[i_page][7];
    sum[2] = |st.temp_flags[i_page];
    sum[1] = |st.cml_flags;
    sum[0] = |st.vendor_flags[i_page] | |st.vout_flags[i_page][6:1] | st.iout_flags[i_page][5] |
             |st.input_flags;
    hi[7] = |st.vout_flags[i_page];
    hi[6] = |st.iout_flags[i_page];
    hi[5] = |st.input_flags;
    hi[4] = |st.vendor_flags[i_page];
    hi[3] = i_pgood_n[i_page];

    // read answer, one cycle after the request
    if (rd) begin
      next_st.rvalid = 1'b1;
      next_st.rerr = !readable(i_cmd_code);
      unique case (i_cmd_code)
        CMD_OT_FAULT_LIM: next_st.rdata = st.ot_fault_lim[i_page];
        CMD_OT_WARN_LIM: next_st.rdata = st.ot_warn_lim[i_page];
        CMD_UT_FAULT_LIM: next_st.rdata = st.ut_fault_lim[i_page];
        CMD_TOFF_LIM: next_st.rdata = st.toff_lim[i_page];
        CMD_TEMP_SLOPE: next_st.rdata = st.slope[i_page];
        CMD_TEMP_ADDEND: next_st.rdata = st.addend[i_page];
        CMD_SUM_BYTE: next_st.rdata = {8'h00, sum};
        CMD_SUM_WORD: next_st.rdata = {hi, sum};
        CMD_VOUT_FLAGS: next_st.rdata = {8'h00, st.vout_flags[i_page]};
        CMD_IOUT_FLAGS: next_st.rdata = {8'h00, st.iout_flags[i_page]};
        CMD_INPUT_FLAGS: next_st.rdata = {8'h00, st.input_flags};
        CMD_TEMP_FLAGS: next_st.rdata = {8'h00, st.temp_flags[i_page]};
        CMD_CML_FLAGS: next_st.rdata = {8'h00, st.cml_flags};
        CMD_VENDOR_FLAGS: next_st.rdata = {8'h00, st.vendor_flags[i_page]};
        CMD_VENDOR_INFO: next_st.rdata = i_vendor_info;
        CMD_PAD_STATE: next_st.rdata = i_pad_state;
        CMD_GENERIC_FLAGS: next_st.rdata = {8'h00, i_generic_flags};
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // alert: any stored flag, temperature bits subject to the mask
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      any_alert = any_alert | |(st.temp_flags[ch] & ~i_temp_alert_mask) |
                  |st.vout_flags[ch] | |st.iout_flags[ch] | |st.vendor_flags[ch] | st.busy[ch];
    end
    next_st.alert = any_alert | |st.input_flags | |st.cml_flags;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.ot_fault_lim <= {NUM_CHAN{RST_OT_FAULT_LIM}};
      st.ot_warn_lim <= {NUM_CHAN{RST_OT_WARN_LIM}};
      st.ut_fault_lim <= {NUM_CHAN{RST_UT_FAULT_LIM}};
      st.toff_lim <= {NUM_CHAN{RST_TOFF_LIM}};
      st.slope <= {NUM_CHAN{RST_TEMP_SLOPE}};
      st.addend <= {NUM_CHAN{RST_TEMP_ADDEND}};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign o_rdata = st.rdata;
  assign o_rvalid = st.rvalid;
  assign o_rerr = st.rerr;
  assign o_ext_temp_slope = st.slope;
  assign o_ext_temp_addend = st.addend;
  assign o_addend_in_volts = st.addend_volts;
  assign o_alert = st.alert;

  // latched fault levels for the protection logic
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_out
    assign o_ot_fault[ch] = st.temp_flags[ch][TEMP_OT_FAULT_BIT];
    assign o_ut_fault[ch] = st.temp_flags[ch][TEMP_UT_FAULT_BIT];
  end

endmodule
`default_nettype wire

// ===== tb/pmt_status_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pmt_status_regs_monitor
  import pmt_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // watched inputs
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [7:0] i_cmd_code,
  input wire logic [1:0] i_temp_valid,
  input wire logic [1:0][7:0] i_modulation_mode_word,
  input wire logic [15:0] i_pad_state,
  input wire logic [7:0] i_temp_alert_mask,
  // watched outputs
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_rerr,
  input wire logic [1:0] o_addend_in_volts,
  input wire logic [1:0] o_ot_fault,
  input wire logic o_alert
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // read strobe taken at this edge
  wire logic rd_req = i_cmd_valid && !i_cmd_write;
  ////////////////////////////////////////
  property p_rd_ans; rd_req |=> o_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_ans; !rd_req |=> !o_rvalid; endproperty
  a_no_ans: assert property (p_no_ans) else $error("answer without read");
  property p_err; o_rerr |-> o_rvalid && o_rdata == 16'h0000; endproperty
  a_err: assert property (p_err) else $error("refusal carries data");
  // view shows the pins as at the strobe
  property p_pad; rd_req && i_cmd_code == CMD_PAD_STATE |=> o_rdata == $past(i_pad_state); endproperty
  a_pad: assert property (p_pad) else $error("pad view mismatch");
  // first edge out of reset is skipped
  property p_volts; $past(i_rst_n) |-> o_addend_in_volts[0] == $past(i_modulation_mode_word[0][5]); endproperty
  a_volts: assert property (p_volts) else $error("addend unit wrong");
  property p_ot_cause; $rose(o_ot_fault[0]) |-> $past(i_temp_valid[0], 2); endproperty
  a_ot_cause: assert property (p_ot_cause) else $error("fault without reading");
  property p_latch; o_ot_fault[0] && !(i_cmd_valid && i_cmd_write) |=> o_ot_fault[0]; endproperty
  a_latch: assert property (p_latch) else $error("fault dropped uncleared");
  property p_alert; (|o_ot_fault) && !i_temp_alert_mask[7] |=> o_alert; endproperty
  a_alert: assert property (p_alert) else $error("alert missing");
  c_err: cover property (o_rerr);
  c_ot: cover property ($rose(o_ot_fault[0]));
  c_alert: cover property ($rose(o_alert));
endmodule
`default_nettype wire

// ===== tb/pmt_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmt_host_model (
  // clock
  input wire logic i_ref_clk,
  // command port toward the device
  output logic o_cmd_valid,
  output logic o_cmd_write,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_cmd_data,
  output logic o_page,
  // read answer
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_rerr
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_data = 16'h0000;
    o_page = 1'b0;
  end
  // one strobe; code and data inverted after so stale values never match
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d, input logic p);
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_write <= w;
    o_cmd_code <= c;
    o_cmd_data <= d;
    o_page <= p;
    @(posedge i_ref_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_code <= ~c;
    o_cmd_data <= ~d;
  endtask
  // answer due one edge after the strobe, else unknown
  task automatic read(input logic [7:0] c, input logic p, output logic [15:0] d, output logic e);
    send(1'b0, c, 16'h0000, p);
    @(posedge i_ref_clk);
    d = i_rdata;
    e = i_rvalid === 1'b1 ? i_rerr : 1'bx;
  endtask
  // send byte with no data
  task automatic clear();
    send(1'b1, 8'h03, 16'h0000, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== tb/pmt_status_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pmt_status_regs_tb
  import pmt_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cmd_valid, i_cmd_write, i_page, o_rvalid, o_rerr, o_alert;
  logic [7:0] i_cmd_code, i_temp_alert_mask = 8'h00, i_input_evt, i_cml_evt, evt = 8'h00;
  logic [15:0] i_cmd_data, o_rdata, i_pad_state = 16'h0000;
  logic [1:0] i_temp_valid = 2'b00, i_fall_done = 2'b00, o_addend_in_volts, o_ot_fault, o_ut_fault;
  logic [1:0][15:0] i_temp_reading = '0, o_ext_temp_slope, o_ext_temp_addend;
  logic [1:0][7:0] i_channel_configuration_word = '0, i_modulation_mode_word = '0;
  logic [1:0][7:0] i_vout_evt, i_iout_evt, i_vendor_evt;
  logic [1:0] i_busy_evt;
  int err_count = 0;
  int samples_checked = 0;
  // one event byte feeds all monitors but busy; channel 1 only the current bits
  assign i_vout_evt = {8'h00, evt};
  assign i_iout_evt = {evt, evt};
  assign i_vendor_evt = {8'h00, evt};
  assign i_busy_evt = 2'b00;
  assign i_input_evt = evt;
  assign i_cml_evt = evt;
  // code and page-0 read after one all-ones event
  logic [23:0] rows [12] = '{24'h4F_EB20, 24'h51_EAA8, 24'h53_E580, 24'h66_F258, 24'hF8_4000,
    24'hF9_8000, 24'h7A_00FE, 24'h7B_00A0, 24'h7C_00A8, 24'h7D_0000, 24'h7E_00FB, 24'h80_00FB};
  // turn-off cases: limit, expected voltage flags
  logic [23:0] toff [3] = '{24'h0001_02, 24'h0000_00, 24'h0001_00};
  always #20 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////
  pmt_host_model HOST (.i_ref_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_write(i_cmd_write),
    .o_cmd_code(i_cmd_code), .o_cmd_data(i_cmd_data), .o_page(i_page), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid), .i_rerr(o_rerr));
  // short tick keeps the millisecond count small
  pmt_status_regs #(.TOFF_TICK_CYCLES(4)) DUT (.i_ref_clk, .i_rst_n, .i_cmd_valid, .i_cmd_write,
    .i_cmd_code, .i_cmd_data, .i_page, .o_rdata, .o_rvalid, .o_rerr, .i_temp_valid, .i_temp_reading,
    .i_fall_done, .i_out_low(2'b00), .i_channel_configuration_word, .i_modulation_mode_word,
    .i_vout_evt, .i_iout_evt, .i_vendor_evt, .i_busy_evt, .i_input_evt, .i_cml_evt,
    .i_chan_off(2'b00), .i_pgood_n(2'b00), .i_pad_state, .i_generic_flags(i_pad_state[7:0]),
    .i_vendor_info(16'h0000), .i_temp_alert_mask, .o_ext_temp_slope, .o_ext_temp_addend,
    .o_addend_in_volts, .o_ot_fault, .o_ut_fault, .o_alert);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // read, compare data and refusal flag
  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic p = 1'b0, input logic eerr = 1'b0);
    logic [15:0] d;
    logic e;
    HOST.read(c, p, d, e);
    chk($sformatf("data of %h", c), exp, d);
    chk($sformatf("refusal of %h", c), 16'(eerr), 16'(e));
  endtask
  task automatic temp_in(input logic [15:0] v);
    @(posedge i_ref_clk);
    i_temp_reading[0] <= v;
    i_temp_valid <= 2'b01;
    @(posedge i_ref_clk);
    i_temp_valid <= 2'b00;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    evt <= 8'hFF;
    @(posedge i_ref_clk);
    evt <= 8'h00;
    foreach (rows[k]) rd(rows[k][23:16], rows[k][15:0]);
    rd(8'h7A, 16'h0000, 1'b1);
    rd(8'h7C, 16'h00A8, 1'b1);
    HOST.send(1'b1, 8'h7B, 16'h0080, 1'b0);
    rd(8'h7B, 16'h0020);
    HOST.clear();
    rd(8'h7A, 16'h0000);
    rd(8'h7C, 16'h0000);
    HOST.send(1'b1, 8'hF8, 16'h1234, 1'b1);
    rd(8'hF8, 16'h4000);
    rd(8'hF8, 16'h1234, 1'b1);
    chk("slope", 16'h1234, o_ext_temp_slope[1]);
    // 101 degrees passes both upper defaults
    temp_in(16'hEB28);
    rd(8'h7D, 16'h00C0);
    rd(8'h7D, 16'h0000, 1'b1);
    rd(8'h78, 16'h0004);
    chk("alert and ot", 16'h0003, {14'h0000, o_alert, o_ot_fault[0]});
    HOST.send(1'b1, 8'h7D, 16'h0080, 1'b0);
    rd(8'h7D, 16'h0040);
    // exactly at the lower threshold is a fault
    temp_in(16'hE580);
    rd(8'h7D, 16'h0050);
    chk("ut level", 16'h0001, 16'(o_ut_fault[0]));
    HOST.clear();
    rd(8'h7D, 16'h0000);
    rd(8'h01, 16'h0000, 1'b0, 1'b1);
    rd(8'h7E, 16'h0080, 1'b1);
    i_pad_state <= 16'hA5C3;
    i_modulation_mode_word[0] <= 8'h20;
    rd(8'hE5, 16'hA5C3, 1'b1);
    rd(8'hEF, 16'h00C3);
    chk("addend unit", 16'h0001, 16'(o_addend_in_volts));
    // output never drops, so only the limit and config bit 0 decide
    foreach (toff[k]) begin
      HOST.clear();
      HOST.send(1'b1, CMD_TOFF_LIM, toff[k][23:8], 1'b0);
      i_channel_configuration_word[0] <= 8'(k == 2);
      i_fall_done <= 2'b01;
      @(posedge i_ref_clk);
      i_fall_done <= 2'b00;
      repeat (40) @(posedge i_ref_clk);
      rd(8'h7A, 16'(toff[k][7:0]));
    end
    report_and_stop();
  end
endmodule
bind pmt_status_regs pmt_status_regs_monitor MON (.i_ref_clk, .i_rst_n, .i_cmd_valid, .i_cmd_write,
  .i_cmd_code, .i_temp_valid, .i_modulation_mode_word, .i_pad_state, .i_temp_alert_mask, .o_rdata,
  .o_rvalid, .o_rerr, .o_addend_in_volts, .o_ot_fault, .o_alert);
`default_nettype wire
